// ===== rtl/psc_defines.svh
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// register byte offsets
`define PSC_OFF_WAKE      12'h000
`define PSC_OFF_CLOCK_DIVIDER_REG    12'h004
`define PSC_OFF_GATE      12'h008
`define PSC_OFF_FUNC_ON   12'h00c
`define PSC_OFF_IDLE_STOP 12'h010
`define PSC_OFF_CTRL      12'h014
`define PSC_OFF_IRQ_STAT  12'h018
`define PSC_OFF_IRQ_MASK  12'h01c

// wake source field positions
`define PSC_WAKE_EXT_INT  8
`define PSC_WAKE_FAULT    7
`define PSC_WAKE_WDOG     4
`define PSC_WAKE_ALARM    3
`define PSC_WAKE_PIN_RST  2
`define PSC_WAKE_POR      0
`define PSC_WAKE_IMPL_MSK 16'h019d

// clock divider field positions
`define PSC_CLOCK_DIVIDER_REG_ROI    15
`define PSC_CLOCK_DIVIDER_REG_RAT_HI 14
`define PSC_CLOCK_DIVIDER_REG_RAT_LO 12
`define PSC_CLOCK_DIVIDER_REG_CPU_SLOWDOWN_ENABLE  11
`define PSC_CLOCK_DIVIDER_REG_MSK    16'hf800

// control register bits
`define PSC_CTRL_DEEP     0
`define PSC_CTRL_IDLE     1

// reset values
`define PSC_RST_WAKE      16'h0000
`define PSC_RST_CLOCK_DIVIDER_REG    16'h0000
`define PSC_RST_GATE      32'h0000_0000
`define PSC_RST_FUNC_ON   32'h0000_0000
`define PSC_RST_IDLE_STOP 32'h0000_0000
`define PSC_RST_CTRL      2'h0
`define PSC_RST_IRQ       6'h00

// value shown on reads of a gated-off module
`define PSC_INVALID_READ  32'hdead_beef

`endif

// ===== rtl/psc_pkg.sv
package psc_pkg;
   typedef struct packed {
      logic ext_int;
      logic fault;
      logic wdog;
      logic alarm;
      logic pin_rst;
      logic por;
   } psc_wake_ev_t;

   typedef struct packed {
      logic [11:0] addr;
      logic        wr;
      logic [31:0] wdata;
   } psc_mod_req_t;

   typedef enum logic [1:0] {
      PSC_CPU_FULL = 2'b01,
      PSC_CPU_DOZE = 2'b10
   } psc_cpu_mode_t;
endpackage : psc_pkg

// ===== rtl/psc_power_ctrl.sv
// Overview of operation
// - external interrupt 0 in deep sleep sets wake bit 8
// - fault during deep sleep sets wake bit 7
// - deep sleep watchdog timeout sets wake bit 4
// - calendar alarm during deep sleep sets wake bit 3
// - master clear pin during deep sleep sets wake bit 2
// - power-on reset event sets wake bit 0
// - only power-on flag may set outside deep sleep
// - unimplemented wake bits read zero
// - doze slows only cpu; peripherals stay at full clock
// - doze entered when clock divider bit 11 set
// - bits 14:12 choose ratio 1:1 to 1:128, default 1:1
// - restore-on-interrupt bit 15 returns cpu to full speed
// - gate bit stops module clocks, blocks writes, invalid reads
// - function-on cleared stops function, registers stay usable
// - modules run in idle unless stop-in-idle bit set
// - capture, compare, calendar modules have no function enable
`timescale 1ns/1ps
`include "psc_defines.svh"

module psc_power_ctrl #(
   parameter int NMOD      = 8,
   parameter int IC_IDX    = 5,
   parameter int OC_IDX    = 6,
   parameter int CAL_IDX   = 7
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire psc_pkg::psc_wake_ev_t wake_ev,
   input  wire logic                cpu_irq,
   output logic                     cpu_clk_en,
   output logic                     periph_clk_en,
   output logic      [NMOD-1:0]     mod_clk_en,
   output logic      [NMOD-1:0]     mod_func_en,
   output logic      [NMOD-1:0]     mod_sel,
   output psc_pkg::psc_mod_req_t    mod_req,
   input  wire logic [NMOD*32-1:0]  mod_rdata,
   output logic                     deep_sleep,
   output logic                     idle_mode,
   output logic                     irq
);
   import psc_pkg::*;

   // ==========================================================
   // bus decode
   // ==========================================================
   logic        acc;
   logic        wr_acc;
   logic        rd_acc;
   logic        hit_mod;
   logic [2:0]  mod_idx;
   assign acc     = psel & penable;
   assign wr_acc  = acc & pwrite;
   assign rd_acc  = acc & ~pwrite;
   assign pready  = 1'b1;
   // module windows sit at 0x100 + 0x20 * index
   assign hit_mod = paddr[11:8] == 4'h1;
   assign mod_idx = paddr[7:5];

   logic unmapped;
   always_comb begin
      unmapped = 1'b0;
      if (!hit_mod) begin
         unique case (paddr)
            `PSC_OFF_WAKE, `PSC_OFF_CLOCK_DIVIDER_REG, `PSC_OFF_GATE,
            `PSC_OFF_FUNC_ON, `PSC_OFF_IDLE_STOP, `PSC_OFF_CTRL,
            `PSC_OFF_IRQ_STAT, `PSC_OFF_IRQ_MASK: unmapped = 1'b0;
            default: unmapped = 1'b1;
         endcase
      end else if (32'(mod_idx) >= NMOD) begin
         unmapped = 1'b1;
      end
   end
   assign pslverr = acc & unmapped;

   // ==========================================================
   // control registers
   // ==========================================================
   logic [15:0]     wake_q;
   logic [15:0]     clock_divider_reg_q;
   logic [NMOD-1:0] gate_q;
   logic [NMOD-1:0] func_on_q;
   logic [NMOD-1:0] idle_stop_q;
   logic [1:0]      ctrl_q;
   logic [5:0]      irq_stat_q;
   logic [5:0]      irq_mask_q;

   logic [NMOD-1:0] no_func_en;
   always_comb begin
      no_func_en = '0;
      no_func_en[IC_IDX]  = 1'b1;
      no_func_en[OC_IDX]  = 1'b1;
      no_func_en[CAL_IDX] = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_divider_reg_q    <= `PSC_RST_CLOCK_DIVIDER_REG;
         gate_q      <= NMOD'(`PSC_RST_GATE);
         func_on_q   <= NMOD'(`PSC_RST_FUNC_ON);
         idle_stop_q <= NMOD'(`PSC_RST_IDLE_STOP);
         ctrl_q      <= `PSC_RST_CTRL;
         irq_mask_q  <= `PSC_RST_IRQ;
      end else if (wr_acc && !hit_mod) begin
         unique case (paddr)
            `PSC_OFF_CLOCK_DIVIDER_REG:
               clock_divider_reg_q <= pwdata[15:0] & `PSC_CLOCK_DIVIDER_REG_MSK;
            `PSC_OFF_GATE:      gate_q      <= pwdata[NMOD-1:0];
            `PSC_OFF_FUNC_ON:
               func_on_q <= pwdata[NMOD-1:0] & ~no_func_en;
            `PSC_OFF_IDLE_STOP: idle_stop_q <= pwdata[NMOD-1:0];
            `PSC_OFF_CTRL:      ctrl_q      <= pwdata[1:0];
            `PSC_OFF_IRQ_MASK:  irq_mask_q  <= pwdata[5:0];
            default: ;
         endcase
      end
   end
   assign deep_sleep = ctrl_q[`PSC_CTRL_DEEP];
   assign idle_mode  = ctrl_q[`PSC_CTRL_IDLE];

   // ==========================================================
   // wake source flags
   // ==========================================================
   // events from the always-on domain arrive as same-clock pulses
   logic [15:0] wake_set;
   always_comb begin
      wake_set = '0;
      wake_set[`PSC_WAKE_EXT_INT] = wake_ev.ext_int & deep_sleep;
      wake_set[`PSC_WAKE_FAULT]   = wake_ev.fault & deep_sleep;
      wake_set[`PSC_WAKE_WDOG]    = wake_ev.wdog & deep_sleep;
      wake_set[`PSC_WAKE_ALARM]   = wake_ev.alarm & deep_sleep;
      wake_set[`PSC_WAKE_PIN_RST] = wake_ev.pin_rst & deep_sleep;
      wake_set[`PSC_WAKE_POR]     = wake_ev.por;
   end

   logic wake_wr;
   assign wake_wr = wr_acc && !hit_mod && paddr == `PSC_OFF_WAKE;

   // set wins over a software clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_q <= `PSC_RST_WAKE;
      end else begin
         wake_q <= ((wake_wr ? pwdata[15:0] & wake_q : wake_q)
                    | wake_set) & `PSC_WAKE_IMPL_MSK;
      end
   end

   // ==========================================================
   // interrupt status, cleared by reading it
   // ==========================================================
   logic [5:0] ev_vec;
   logic       stat_rd;
   assign ev_vec  = {wake_set[8], wake_set[7], wake_set[4],
                     wake_set[3], wake_set[2], wake_set[0]};
   assign stat_rd = rd_acc && !hit_mod && paddr == `PSC_OFF_IRQ_STAT;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= `PSC_RST_IRQ;
      end else begin
         irq_stat_q <= (stat_rd ? 6'h00 : irq_stat_q) | ev_vec;
      end
   end
   assign irq = |(irq_stat_q & irq_mask_q);

   // ==========================================================
   // doze divider
   // ==========================================================
   logic [6:0]    doze_cnt_q;
   logic [6:0]    doze_lim;
   psc_cpu_mode_t mode_q;
   logic          doze_on;
   assign doze_on  = clock_divider_reg_q[`PSC_CLOCK_DIVIDER_REG_CPU_SLOWDOWN_ENABLE];
   // ratio 2^n - 1 wraps the counter: 1:1 .. 1:128
   assign doze_lim = 7'((8'h01 << clock_divider_reg_q[14:12]) - 8'h01);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= PSC_CPU_FULL;
      end else begin
         unique case (mode_q)
            PSC_CPU_FULL: begin
               if (doze_on && !(cpu_irq && clock_divider_reg_q[`PSC_CLOCK_DIVIDER_REG_ROI]))
                  mode_q <= PSC_CPU_DOZE;
            end
            PSC_CPU_DOZE: begin
               if (!doze_on)
                  mode_q <= PSC_CPU_FULL;
               else if (cpu_irq && clock_divider_reg_q[`PSC_CLOCK_DIVIDER_REG_ROI])
                  mode_q <= PSC_CPU_FULL;
            end
            default: mode_q <= PSC_CPU_FULL;
         endcase
      end
   end

   // after a restore, doze is re-entered once cpu_irq drops with the doze bit still set;
   // interrupts alone never end it while restore is off
   logic doze_wr;
   assign doze_wr = wr_acc && !hit_mod && paddr == `PSC_OFF_CLOCK_DIVIDER_REG;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         doze_cnt_q <= '0;
      end else if (mode_q != PSC_CPU_DOZE || doze_wr) begin
         doze_cnt_q <= '0;
      end else if (doze_cnt_q >= doze_lim) begin
         doze_cnt_q <= '0;
      end else begin
         doze_cnt_q <= doze_cnt_q + 7'h01;
      end
   end

   // one cpu enable per ratio period; peripherals always run
   assign cpu_clk_en    = (mode_q == PSC_CPU_FULL) ||
                          (doze_cnt_q == 7'h00);
   assign periph_clk_en = 1'b1;

   // ==========================================================
   // per-module gating
   // ==========================================================
   assign mod_clk_en  = ~gate_q & ~(idle_stop_q & {NMOD{idle_mode}});
   assign mod_func_en = mod_clk_en & (func_on_q | no_func_en);

   // gated modules see no select, so writes are dropped
   always_comb begin
      mod_sel = '0;
      if (psel && hit_mod && 32'(mod_idx) < NMOD)
         mod_sel[mod_idx] = ~gate_q[mod_idx];
   end
   assign mod_req.addr  = {7'h00, paddr[4:0]};
   assign mod_req.wr    = pwrite & penable;
   assign mod_req.wdata = pwdata;

   // ==========================================================
   // read data
   // ==========================================================
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_mod) begin
         if (32'(mod_idx) < NMOD) begin
            if (gate_q[mod_idx])
               rd_mux = `PSC_INVALID_READ;
            else
               rd_mux = mod_rdata[32*mod_idx +: 32];
         end
      end else begin
         unique case (paddr)
            `PSC_OFF_WAKE:      rd_mux = {16'h0000, wake_q};
            `PSC_OFF_CLOCK_DIVIDER_REG:    rd_mux = {16'h0000, clock_divider_reg_q};
            `PSC_OFF_GATE:      rd_mux = 32'(gate_q);
            `PSC_OFF_FUNC_ON:   rd_mux = 32'(func_on_q);
            `PSC_OFF_IDLE_STOP: rd_mux = 32'(idle_stop_q);
            `PSC_OFF_CTRL:      rd_mux = {30'h0, ctrl_q};
            `PSC_OFF_IRQ_STAT:  rd_mux = {26'h0, irq_stat_q};
            `PSC_OFF_IRQ_MASK:  rd_mux = {26'h0, irq_mask_q};
            default:            rd_mux = 32'h0000_0000;
         endcase
      end
   end
   assign prdata = rd_acc ? rd_mux : 32'h0000_0000;

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_wake_ext_int: assert property (wake_ev.ext_int && deep_sleep |=>
      wake_q[8]) else $error("ext int wake not recorded");
   a_wake_fault: assert property (wake_ev.fault && deep_sleep |=>
      wake_q[7]) else $error("fault wake not recorded");
   a_wake_wdog: assert property (wake_ev.wdog && deep_sleep |=>
      wake_q[4]) else $error("watchdog wake not recorded");
   a_wake_alarm: assert property (wake_ev.alarm && deep_sleep |=>
      wake_q[3]) else $error("alarm wake not recorded");
   a_wake_pinrst: assert property (wake_ev.pin_rst && deep_sleep |=>
      wake_q[2]) else $error("pin reset wake not recorded");
   a_wake_por: assert property (wake_ev.por |=> wake_q[0])
      else $error("power-on wake not recorded");
   a_awake_no_set: assert property (!deep_sleep && !wake_wr |=>
      (wake_q & 16'h019c) == ($past(wake_q) & 16'h019c))
      else $error("wake flag set outside deep sleep");
   a_wake_unimpl: assert property ((wake_q & 16'hfe62) == 16'h0000)
      else $error("unimplemented wake bit set");
   a_wake_sticky: assert property (wake_q[8] && !wake_wr |=> wake_q[8])
      else $error("wake flag lost without write");
   a_wake_clear: assert property (wake_wr && !pwdata[8] && !wake_set[8]
      |=> !wake_q[8]) else $error("wake flag not cleared");

   // a status read in the cycle of an event must not lose the event
   a_stat_set: assert property (ev_vec != 6'h00 |=>
      (irq_stat_q & $past(ev_vec)) == $past(ev_vec))
      else $error("event not latched in status");
   a_stat_clear: assert property (stat_rd && ev_vec == 6'h00 |=>
      irq_stat_q == 6'h00) else $error("status not cleared by read");

   sequence s_doze_steady;
      mode_q == PSC_CPU_DOZE && clock_divider_reg_q[14:12] == 3'h1 && !doze_wr;
   endsequence
   a_doze_ratio: assert property ((s_doze_steady and cpu_clk_en)
      ##1 s_doze_steady |-> !cpu_clk_en)
      else $error("doze ratio not applied");
   a_doze_enter: assert property (mode_q == PSC_CPU_FULL && doze_on &&
      !cpu_irq |=> mode_q == PSC_CPU_DOZE)
      else $error("doze not entered");
   a_doze_exit: assert property (mode_q == PSC_CPU_DOZE && !doze_on |=>
      mode_q == PSC_CPU_FULL) else $error("doze not left");
   a_roi_exit: assert property (mode_q == PSC_CPU_DOZE && cpu_irq &&
      clock_divider_reg_q[15] |=> mode_q == PSC_CPU_FULL)
      else $error("restore on interrupt failed");
   a_roi_off: assert property (mode_q == PSC_CPU_DOZE && doze_on &&
      !clock_divider_reg_q[15] && !doze_wr |=> mode_q == PSC_CPU_DOZE)
      else $error("interrupt left doze");
   a_full_hold: assert property (mode_q == PSC_CPU_FULL && cpu_irq &&
      clock_divider_reg_q[15] |=> mode_q == PSC_CPU_FULL)
      else $error("doze entered during restore");

   a_gate_off: assert property ((gate_q & mod_clk_en) == '0 &&
      (gate_q & mod_sel) == '0) else $error("gated module live");
   a_gate_read: assert property (rd_acc && hit_mod &&
      32'(mod_idx) < NMOD && gate_q[mod_idx] |->
      prdata == `PSC_INVALID_READ) else $error("gated module read valid");
   a_func_ic: assert property (!func_on_q[IC_IDX])
      else $error("capture has enable bit");
   a_idle_stop: assert property (idle_mode |->
      (idle_stop_q & mod_clk_en) == '0)
      else $error("module ran in idle");
   a_idle_run: assert property (!idle_mode |->
      (mod_clk_en | gate_q) == {NMOD{1'b1}})
      else $error("module stopped outside idle");
endmodule : psc_power_ctrl

// ===== tb/tb.sv
`timescale 1ns/1ps
`include "psc_defines.svh"

module tb;
   import psc_pkg::*;

   // ==========================================
   // signals
   logic          pclk, presetn, psel, penable, pwrite, cpu_irq;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, rd;
   logic          pready, pslverr, cpu_clk_en, periph_clk_en, er;
   logic          deep_sleep, idle_mode, irq;
   logic [7:0]    mod_clk_en, mod_func_en, mod_sel, ms;
   logic [255:0]  mod_rdata;
   psc_wake_ev_t  wake_ev;
   psc_mod_req_t  mod_req, mq;
   int            err_count, total_checks, n;

   psc_power_ctrl psc_power_ctrl_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .wake_ev(wake_ev),
      .cpu_irq(cpu_irq), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en), .mod_clk_en(mod_clk_en),
      .mod_func_en(mod_func_en), .mod_sel(mod_sel), .mod_req(mod_req),
      .mod_rdata(mod_rdata), .deep_sleep(deep_sleep),
      .idle_mode(idle_mode), .irq(irq));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // ==========================================
   // shared tasks
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   // master holds the request until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         err_count++;
         $display("mismatch at %0t: no pready", $time);
         wrap_up();
      end
      rd = prdata;
      er = pslverr;
      ms = mod_sel;
      mq = mod_req;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      // the write lands at the access edge: let registers settle
      @(negedge pclk);
   endtask : wr

   task automatic rc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp, "read data");
      chk(er, 1'b0, "slave error");
   endtask : rc

   task automatic pulse(input psc_wake_ev_t e);
      @(posedge pclk);
      wake_ev <= e;
      @(posedge pclk);
      wake_ev <= '0;
   endtask : pulse

   // counts cpu clock enables over one 1:128 period
   task automatic cnt();
      n = 0;
      repeat (128) begin
         @(negedge pclk);
         n += (cpu_clk_en === 1'b1);
         chk(periph_clk_en, 1'b1, "periph clock");
      end
   endtask : cnt

   // ==========================================
   // scenarios
   task automatic t_reset();
      chk(cpu_clk_en, 1'b1, "cpu clock after reset");
      chk(mod_clk_en, 8'hff, "module clocks after reset");
      chk(mod_func_en, 8'he0, "functions after reset");
      chk(irq, 1'b0, "irq after reset");
      rc(`PSC_OFF_WAKE, 32'h0000_0000);
      rc(`PSC_OFF_CLOCK_DIVIDER_REG, 32'h0000_0000);
      apb(1'b0, 12'h0fc, 32'h0000_0000);
      chk(er, 1'b1, "unmapped error");
      chk(rd, 32'h0000_0000, "unmapped read");
      $display("test reset done");
   endtask : t_reset

   task automatic t_wake();
      pulse(6'h3f);
      rc(`PSC_OFF_WAKE, 32'h0000_0001);
      wr(`PSC_OFF_IRQ_MASK, 32'h0000_003f);
      apb(1'b0, `PSC_OFF_IRQ_STAT, 32'h0000_0000);
      wr(`PSC_OFF_WAKE, 32'h0000_0000);
      wr(`PSC_OFF_CTRL, 32'h0000_0001);
      chk(deep_sleep, 1'b1, "deep sleep entered");
      for (int i = 0; i < 6; i++)
         pulse(6'h01 << i);
      rc(`PSC_OFF_WAKE, 32'h0000_019d);
      chk(irq, 1'b1, "irq raised");
      wr(`PSC_OFF_WAKE, 32'h0000_ffff);
      rc(`PSC_OFF_WAKE, 32'h0000_019d);
      wr(`PSC_OFF_WAKE, 32'h0000_0000);
      rc(`PSC_OFF_WAKE, 32'h0000_0000);
      rc(`PSC_OFF_IRQ_STAT, 32'h0000_003f);
      rc(`PSC_OFF_IRQ_STAT, 32'h0000_0000);
      chk(irq, 1'b0, "irq cleared by read");
      wr(`PSC_OFF_IRQ_MASK, 32'h0000_0000);
      pulse(6'h20);
      @(negedge pclk);
      chk(irq, 1'b0, "masked irq");
      rc(`PSC_OFF_WAKE, 32'h0000_0100);
      wr(`PSC_OFF_WAKE, 32'h0000_0000);
      wr(`PSC_OFF_CTRL, 32'h0000_0000);
      $display("test wake done");
   endtask : t_wake

   task automatic t_doze();
      for (int r = 0; r < 8; r++) begin
         wr(`PSC_OFF_CLOCK_DIVIDER_REG, 32'h0000_0800 | (r << 12));
         cnt();
         chk(n, 128 >> r, "cpu clock ratio");
      end
      wr(`PSC_OFF_CLOCK_DIVIDER_REG, 32'h0000_3800);
      @(posedge pclk);
      cpu_irq <= 1'b1;
      cnt();
      chk(n, 16, "irq ignored without restore");
      wr(`PSC_OFF_CLOCK_DIVIDER_REG, 32'h0000_b800);
      cnt();
      chk(n, 128, "restore on interrupt");
      @(posedge pclk);
      cpu_irq <= 1'b0;
      wr(`PSC_OFF_CLOCK_DIVIDER_REG, 32'h0000_0000);
      cnt();
      chk(n, 128, "full speed");
      $display("test doze done");
   endtask : t_doze

   task automatic t_gate();
      rc(12'h100, 32'hc0de_0000);
      wr(`PSC_OFF_GATE, 32'h0000_0001);
      chk(mod_clk_en, 8'hfe, "gated clock");
      rc(12'h100, `PSC_INVALID_READ);
      wr(12'h104, 32'h1234_5678);
      chk(ms, 8'h00, "gated select");
      wr(`PSC_OFF_FUNC_ON, 32'h0000_00ff);
      rc(`PSC_OFF_FUNC_ON, 32'h0000_001f);
      chk(mod_func_en, 8'hfe, "functions on");
      wr(`PSC_OFF_FUNC_ON, 32'h0000_001d);
      chk(mod_func_en, 8'hfc, "function off");
      rc(12'h120, 32'hc0de_0001);
      wr(12'h124, 32'h0000_5a5a);
      chk(ms, 8'h02, "module select");
      chk({mq.wr, mq.addr, mq.wdata[15:0]}, 32'h1004_5a5a,
          "module request");
      wr(`PSC_OFF_IDLE_STOP, 32'h0000_0004);
      chk(mod_clk_en, 8'hfe, "idle stop outside idle");
      wr(`PSC_OFF_CTRL, 32'h0000_0002);
      chk(idle_mode, 1'b1, "idle entered");
      chk(mod_clk_en, 8'hfa, "idle stop in idle");
      chk(mod_func_en, 8'hf8, "function in idle");
      wr(`PSC_OFF_CTRL, 32'h0000_0000);
      wr(`PSC_OFF_GATE, 32'h0000_0000);
      chk(mod_clk_en, 8'hff, "clocks back");
      $display("test gate done");
   endtask : t_gate

   // ==========================================
   // main sequence
   initial begin
      presetn      = 1'b0;
      psel         = 1'b0;
      penable      = 1'b0;
      pwrite       = 1'b0;
      paddr        = '0;
      pwdata       = '0;
      cpu_irq      = 1'b0;
      wake_ev      = '0;
      err_count    = 0;
      total_checks = 0;
      for (int i = 0; i < 8; i++)
         mod_rdata[32*i +: 32] = 32'hc0de_0000 | i;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_wake();
      t_doze();
      t_gate();
      wrap_up();
   end
endmodule : tb
